/* File: eps_defines.vh */
// Constants for the serial memory slave: address pattern, timing counts.
// Assumes a 100 MHz reference clock; included by the slave design file.
`ifndef EPS_DEFINES_VH
`define EPS_DEFINES_VH
`define EPS_CLK_MHZ 100
`define EPS_DEV_TYPE 4'ha
`define EPS_PROG_TIME_MS 5
`define EPS_PROG_CYCLES (`EPS_PROG_TIME_MS * 1000 * `EPS_CLK_MHZ)
`define EPS_PU_TIME_MS 1
`define EPS_PU_CYCLES (`EPS_PU_TIME_MS * 1000 * `EPS_CLK_MHZ)
`define EPS_GROUP_BYTES 4
`define EPS_CHECK_BITS 6
`define EPS_WORD_BITS 38
`define EPS_ERASED_BYTE 8'hff
`endif

/* File: eps_mem.v */
// Protected memory: each word holds four data bytes and six check bits.
// Assumes the caller applies a write and a read in separate cycles.
`timescale 1ns/1ps
module eps_mem #(
  parameter AW = 6,
  parameter DW = 38
) (
  input wire clk, // Clock.
  input wire we, // Write strobe.
  input wire [AW-1:0] addr, // Word index.
  input wire [DW-1:0] wdata, // Word to store.
  output reg [DW-1:0] rdata // Registered read word.
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // eps_mem

/* File: eps_slave.v */
// Serial memory slave: bus protocol, write protect, power-up and ECC.
// Assumes scl, sda and pin straps are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "eps_defines.vh"
module eps_slave #(
  parameter AW = 6,
  parameter PROG_CYCLES = `EPS_PROG_CYCLES,
  parameter PU_CYCLES = `EPS_PU_CYCLES
) (
  input wire ref_clk, // Reference clock.
  input wire resetn, // Asynchronous reset, low active.
  input wire scl_in, // Serial clock from master.
  input wire sda_in, // Serial data level.
  output reg sda_out, // Data drive value, always low.
  output reg sda_oe_n, // Low while pulling data low.
  input wire protect_in, // Write protect, pulled low.
  input wire device_select_bit0, // Select strap 0.
  input wire device_select_bit1, // Select strap 1.
  input wire device_select_bit2, // Select strap 2.
  output reg ready_q, // High once power-up delay passed.
  output reg busy_q, // High during internal program time.
  output reg ecc_fix_q // Pulse on nonzero read syndrome, for each read byte except the first of a read.
);
  localparam S_IDLE = 7'h01, S_ADDR = 7'h02, S_AHI = 7'h04, S_ALO = 7'h08;
  localparam S_WDAT = 7'h10, S_RDAT = 7'h20, S_SKIP = 7'h40;
  localparam CW = 32;
  reg [2:0] scl_s, sda_s;
  reg [1:0] wp_s, a0_s, a1_s, a2_s;
  reg [6:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] bit_q;
  reg ack_ph_q, rd_q, wp_hold_q, mack_q, want_q;
  reg wp_due_q;
  reg [AW+1:0] ptr_q;
  reg [31:0] page_q;
  reg [3:0] dirty_q;
  reg [AW-1:0] pword_q;
  reg [CW-1:0] pu_cnt_q, wr_cnt_q;
  reg mem_we_q;
  reg [`EPS_WORD_BITS-1:0] mem_wd_q;
  wire [`EPS_WORD_BITS-1:0] mem_rd;
  reg [7:0] out_byte_q;
  reg [1:0] load_q;
  // Samples from two-stage synchronisers; stage two onward only.
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c = scl_s[2] & scl & sda_s[2] & ~sda;
  wire stop_c = scl_s[2] & scl & ~sda_s[2] & sda;
  wire [2:0] sel = {a2_s[1], a1_s[1], a0_s[1]};
  // Hamming-style check bits over 32 data bits, 6 parity groups.
  function [5:0] ecc_of;
    input [31:0] d;
    integer i;
    begin
      ecc_of = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (d[i]) begin
          ecc_of = ecc_of ^ i[5:0] ^ 6'h20;
        end
      end
    end
  endfunction
  function [5:0] pos_code;
    input [5:0] p;
    begin
      pos_code = p ^ 6'h20;
    end
  endfunction
  // Syndrome locates the single flipped data bit in the stored word.
  wire [5:0] syn = ecc_of(mem_rd[31:0]) ^ mem_rd[37:32];
  reg [31:0] fixed;
  integer k;
  always @* begin
    fixed = mem_rd[31:0];
    for (k = 0; k < 32; k = k + 1) begin
      if (syn != 6'h00 && syn == pos_code(k[5:0])) begin
        fixed[k] = ~mem_rd[k];
      end
    end
  end
  eps_mem #(.AW(AW), .DW(`EPS_WORD_BITS)) u_mem (
    .clk(ref_clk),
    .we(mem_we_q),
    .addr(mem_we_q ? pword_q : ptr_q[AW+1:2]),
    .wdata(mem_wd_q),
    .rdata(mem_rd)
  );
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      wp_s <= 2'h0;
      a0_s <= 2'h0;
      a1_s <= 2'h0;
      a2_s <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      wp_s <= {wp_s[0], protect_in};
      a0_s <= {a0_s[0], device_select_bit0};
      a1_s <= {a1_s[0], device_select_bit1};
      a2_s <= {a2_s[0], device_select_bit2};
    end
  end
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ack_ph_q <= 1'b0;
      rd_q <= 1'b0;
      wp_hold_q <= 1'b0;
      wp_due_q <= 1'b0;
      mack_q <= 1'b0;
      want_q <= 1'b0;
      ptr_q <= {(AW+2){1'b0}};
      page_q <= 32'h00000000;
      dirty_q <= 4'h0;
      pword_q <= {AW{1'b0}};
      pu_cnt_q <= {CW{1'b0}};
      wr_cnt_q <= {CW{1'b0}};
      ready_q <= 1'b0;
      busy_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wd_q <= {`EPS_WORD_BITS{1'b0}};
      out_byte_q <= `EPS_ERASED_BYTE;
      load_q <= 2'h0;
      ecc_fix_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      mem_we_q <= 1'b0;
      ecc_fix_q <= 1'b0;
      sda_out <= 1'b0;
      if (!ready_q) begin
        pu_cnt_q <= pu_cnt_q + 1'b1;
        if (pu_cnt_q == PU_CYCLES - 1) begin
          ready_q <= 1'b1;
        end
      end
      if (busy_q) begin
        wr_cnt_q <= wr_cnt_q + 1'b1;
        if (wr_cnt_q == PROG_CYCLES - 1) begin
          busy_q <= 1'b0;
        end
      end
      // Read-modify-write: fetch old group, merge new bytes, re-encode.
      if (load_q == 2'h1) begin
        load_q <= 2'h2;
      end else if (load_q == 2'h2) begin
        load_q <= 2'h0;
        begin : merge
          reg [31:0] m;
          integer b;
          m = fixed;
          for (b = 0; b < 4; b = b + 1) begin
            if (dirty_q[b]) begin
              m[8*b +: 8] = page_q[8*b +: 8];
            end
          end
          mem_we_q <= 1'b1;
          mem_wd_q <= {ecc_of(m), m};
        end
        dirty_q <= 4'h0;
      end
      if (!ready_q) begin
        st_q <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        sda_oe_n <= 1'b1;
        if (st_q == S_WDAT && dirty_q != 4'h0 && !wp_hold_q) begin
          busy_q <= 1'b1;
          wr_cnt_q <= {CW{1'b0}};
          load_q <= 2'h1;
        end
      end else if (start_c) begin
        st_q <= S_ADDR;
        bit_q <= 4'h0;
        ack_ph_q <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (ack_ph_q) begin
          mack_q <= ~sda;
        end else if (st_q != S_IDLE && st_q != S_RDAT) begin
          sh_q <= {sh_q[6:0], sda};
          bit_q <= bit_q + 1'b1;
        end else if (st_q == S_RDAT) begin
          bit_q <= bit_q + 1'b1;
        end
      end else if (scl_fall) begin
        if (ack_ph_q) begin
          ack_ph_q <= 1'b0;
          sda_oe_n <= 1'b1;
          bit_q <= 4'h0;
          // The fall closing the address ack is the last before data.
          if (wp_due_q) begin
            wp_hold_q <= wp_s[1];
            wp_due_q <= 1'b0;
          end
          if (st_q == S_RDAT) begin
            if (!mack_q) begin
              st_q <= S_SKIP;
            end else begin
              out_byte_q <= fixed[8*ptr_q[1:0] +: 8];
              ecc_fix_q <= (syn != 6'h00);
              ptr_q <= ptr_q + 1'b1;
              sda_oe_n <= fixed[8*ptr_q[1:0] + 7];
            end
          end else if (want_q) begin
            st_q <= S_RDAT;
            out_byte_q <= fixed[8*ptr_q[1:0] +: 8];
            ptr_q <= ptr_q + 1'b1;
            sda_oe_n <= fixed[8*ptr_q[1:0] + 7];
            want_q <= 1'b0;
          end
        end else if (st_q == S_RDAT) begin
          if (bit_q == 4'h8) begin
            ack_ph_q <= 1'b1;
            sda_oe_n <= 1'b1;
          end else begin
            sda_oe_n <= out_byte_q[3'h7 - bit_q[2:0]];
          end
        end else if (bit_q == 4'h8) begin
          case (st_q)
            S_ADDR: begin
              // Busy, wrong pattern or other select: leave the bus alone.
              if (sh_q[7:4] == `EPS_DEV_TYPE && sh_q[3:1] == sel
                  && !busy_q) begin
                ack_ph_q <= 1'b1;
                sda_oe_n <= 1'b0;
                rd_q <= sh_q[0];
                want_q <= sh_q[0];
                st_q <= sh_q[0] ? S_ADDR : S_AHI;
              end else begin
                st_q <= S_SKIP;
              end
            end
            S_AHI: begin
              ack_ph_q <= 1'b1;
              sda_oe_n <= 1'b0;
              st_q <= S_ALO;
            end
            S_ALO: begin
              ptr_q <= sh_q[AW+1:0];
              pword_q <= sh_q[AW+1:2];
              dirty_q <= 4'h0;
              wp_due_q <= 1'b1;
              ack_ph_q <= 1'b1;
              sda_oe_n <= 1'b0;
              st_q <= S_WDAT;
            end
            S_WDAT: begin
              if (wp_hold_q) begin
                st_q <= S_SKIP;
              end else begin
                // Bytes stay within the group; later ones overwrite.
                page_q[8*ptr_q[1:0] +: 8] <= sh_q;
                dirty_q[ptr_q[1:0]] <= 1'b1;
                ptr_q[1:0] <= ptr_q[1:0] + 2'h1;
                ack_ph_q <= 1'b1;
                sda_oe_n <= 1'b0;
              end
            end
            default: st_q <= S_SKIP;
          endcase
        end
      end
    end
  end
endmodule // eps_slave

/* File: eps_slave_properties.sv */
// Port checker for the serial memory slave.
// Assumes a bind onto eps_slave and its two shortened counts.
`timescale 1ns/1ps
module eps_chk #(
  parameter PROG_CYCLES = 200,
  parameter PU_CYCLES = 200
) (
  input wire ref_clk, // Clock.
  input wire resetn, // Reset, low active.
  input wire scl_in, // Bus clock.
  input wire sda_out, // Drive value.
  input wire sda_oe_n, // Drive enable.
  input wire ready_q, // Ready flag.
  input wire busy_q // Program busy.
);
  reg [31:0] up_q;
  reg [31:0] bz_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 32'h0;
      bz_q <= 32'h0;
    end else begin
      up_q <= up_q + 32'h1;
      bz_q <= busy_q ? bz_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_pull;
    $fell(sda_oe_n);
  endsequence
  sequence s_hold;
    !sda_oe_n [*3];
  endsequence
  AST_OPEN_DRAIN: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  AST_STANDBY: assert property ($rose(resetn) |-> sda_oe_n && !ready_q)
    else $error("state not cleared by reset");
  AST_QUIET: assert property (!ready_q |-> sda_oe_n)
    else $error("answer before ready");
  AST_READY_EARLY: assert property (up_q < PU_CYCLES - 2 |-> !ready_q)
    else $error("ready too early");
  AST_READY_LATE: assert property (up_q > PU_CYCLES + 4 |-> ready_q)
    else $error("ready too late");
  AST_BUSY_QUIET: assert property (busy_q |-> sda_oe_n)
    else $error("answer while programming");
  AST_BUSY_MAX: assert property (busy_q |-> bz_q <= PROG_CYCLES)
    else $error("program time too long");
  AST_BUSY_MIN: assert property ($fell(busy_q) |-> bz_q >= PROG_CYCLES - 2)
    else $error("program time too short");
  AST_PULL_AFTER_FALL: assert property (s_pull |-> $past(!scl_in, 2))
    else $error("pull not after clock fall");
  AST_FREE_AFTER_FALL: assert property ($rose(sda_oe_n) |-> $past(!scl_in, 2))
    else $error("release not after clock fall");
  AST_PULL_STANDS: assert property (s_pull |=> s_hold)
    else $error("low drive too short");
endmodule // eps_chk
bind eps_slave eps_chk #(.PROG_CYCLES(PROG_CYCLES), .PU_CYCLES(PU_CYCLES))
  chk_u (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ready_q(ready_q),
  .busy_q(busy_q));

/* File: eps_mstr.sv */
// Bus master model: eight reference clocks per bus bit.
// Assumes each task is entered just after a reference clock rise.
`timescale 1ns/1ps
module eps_mstr (
  input wire ref_clk, // Clock.
  input wire sda, // Resolved data line.
  output reg scl = 1'b1, // Bus clock, idle high.
  output reg sda_low = 1'b0 // Pulls data low.
);
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task bit_io(input b, output r);
    begin
      sda_low <= !b;
      tick(2);
      scl <= 1'b1;
      tick(3);
      r = sda;
      tick(1);
      scl <= 1'b0;
      tick(2);
    end
  endtask
  task start;
    begin
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
    end
  endtask
  task stop;
    begin
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
    end
  endtask
  // The second argument is the bit sent in the acknowledge slot.
  task xfer(input [7:0] w, input last, output [7:0] r, output ack);
    integer i;
    reg b;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(w[i], b);
        r[i] = b;
      end
      bit_io(last, b);
      ack = !b;
    end
  endtask
endmodule // eps_mstr

/* File: eps_slave_test.sv */
// Self-checking bench for eps_slave with the master model.
// Assumes protect and select straps have pull-downs on the board.
`timescale 1ns/1ps
module eps_slave_test;
  reg ref_clk = 1'b0;
  reg resetn = 1'b0;
  reg prot_q = 1'b0;
  reg sel_en = 1'b0;
  reg [2:0] sel_q = 3'h0;
  reg [7:0] r;
  reg a;
  reg fix_seen = 1'b0;
  wire ecc_fix;
  integer n_fail = 0;
  integer checked = 0;
  integer i;
  wire scl, sda_low, sda_out, sda_oe_n, ready_q, busy_q;
  tri0 prot_w;
  tri0 [2:0] sel_w;
  wire sda = !(sda_low || (!sda_oe_n && !sda_out));
  assign prot_w = prot_q ? 1'b1 : 1'bz;
  assign sel_w = sel_en ? sel_q : 3'hz;
  always #5 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    if (ecc_fix !== 1'b0) fix_seen <= 1'b1;
  end
  eps_slave #(.PROG_CYCLES(200), .PU_CYCLES(200)) dut_u (.ref_clk(ref_clk),
    .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .protect_in(prot_w),
    .device_select_bit0(sel_w[0]), .device_select_bit1(sel_w[1]),
    .device_select_bit2(sel_w[2]), .ready_q(ready_q),
    .busy_q(busy_q), .ecc_fix_q(ecc_fix));
  eps_mstr mdl_u (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task idle;
    integer k;
    begin
      k = 0;
      while ((ready_q !== 1'b1 || busy_q !== 1'b0) && k < 400) begin
        @(posedge ref_clk);
        k = k + 1;
      end
      if (k == 400) begin
        chk(8'h0, 8'h1);
        end_sim;
      end
    end
  endtask
  task go(input [7:0] b, input ok);
    begin
      mdl_u.start;
      mdl_u.xfer(b, 1'b1, r, a);
      chk({7'h0, a}, {7'h0, ok});
    end
  endtask
  task ptr(input [15:0] ad, input rw);
    begin
      go({4'ha, sel_w, 1'b0}, 1'b1);
      mdl_u.xfer(ad[15:8], 1'b1, r, a);
      mdl_u.xfer(ad[7:0], 1'b1, r, a);
      chk({7'h0, a}, 8'h1);
      if (rw) go({4'ha, sel_w, 1'b1}, 1'b1);
    end
  endtask
  task wr(input [15:0] ad, input [31:0] d, input integer n, input ok);
    begin
      ptr(ad, 1'b0);
      for (i = 0; i < n; i = i + 1) begin
        mdl_u.xfer(d[31-8*i -: 8], 1'b1, r, a);
        chk({7'h0, a}, {7'h0, ok});
      end
      mdl_u.stop;
      mdl_u.tick(4);
    end
  endtask
  task rd(input [31:0] e);
    begin
      ptr(16'h0004, 1'b1);
      for (i = 0; i < 4; i = i + 1) begin
        mdl_u.xfer(8'hff, i == 3, r, a);
        chk(r, e[31-8*i -: 8]);
      end
      mdl_u.stop;
    end
  endtask
  task t_sel;
    begin
      sel_en <= 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        sel_q <= i[2:0];
        go({4'ha, i[2:0], 1'b0}, 1'b1);
        mdl_u.stop;
        go({4'ha, ~i[2:0], 1'b0}, 1'b0);
        mdl_u.stop;
      end
      sel_en <= 1'b0;
      mdl_u.tick(1);
    end
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk({6'h0, ready_q, sda_oe_n}, 8'h1);
    @(posedge ref_clk);
    go(8'ha0, 1'b0);
    mdl_u.stop;
    idle;
    t_sel;
    wr(16'h0004, 32'h11223344, 4, 1'b1);
    go(8'ha0, 1'b0);
    mdl_u.stop;
    idle;
    rd(32'h11223344);
    wr(16'h0006, 32'h5a000000, 1, 1'b1);
    idle;
    rd(32'h11225a44);
    prot_q <= 1'b1;
    wr(16'h0004, 32'hdeadbeef, 4, 1'b0);
    chk({7'h0, busy_q}, 8'h0);
    prot_q <= 1'b0;
    rd(32'h11225a44);
    go(8'ha1, 1'b1);
    resetn <= 1'b0;
    @(negedge ref_clk);
    chk({6'h0, ready_q, sda_oe_n}, 8'h1);
    @(posedge ref_clk);
    resetn <= 1'b1;
    mdl_u.stop;
    idle;
    rd(32'h11225a44);
    chk({7'h0, fix_seen}, 8'h0);
    end_sim;
  end
endmodule // eps_slave_test
